// File: src/counter_array.sv
// How it works
// - One 16-bit up-counter and three 16-bit capture/compare channels, each with a pin.
// - Reading the low byte snapshots the high byte; high byte reads return the snapshot.
// - Counter reads never disturb counting.
// - Timebase selects sysclk/12, sysclk/4, timer 0 overflow, count pin, sysclk, osc/8.
// - Count pin mode counts falling edges; source no faster than sysclk/4.
// - Oscillator divided by eight is synchronised before it counts.
// - Wrap from all-ones to zero sets the overflow flag, interrupts if enabled.
// - Overflow flag stays set until software clears it.
// - Idle suspend clear keeps the array running in idle.
// - Capture mode picks rising, falling or either edge from the two edge bits.
// - Compare enable plus match alone gives software timer mode.
// - Toggle, match and compare enable give toggle-on-match output mode.
// - Toggle plus PWM gives frequency output; PWM alone gives 8 or 16-bit PWM.
// - A channel flag interrupt enable lets its flag request an interrupt.
// - A qualifying capture edge loads the counter into the channel register.
// - Capture sets the channel flag; only software clears it.
// - Pin levels count only after holding two clock cycles.
// - Compare match sets the channel flag when the match bit is set, interrupting if enabled.
// - Low byte write clears compare enable; high byte write sets it.
// - Toggle mode inverts the pin at every match after its first cycle.
// - Toggle output starts at one and reinitialises on entering toggle mode.
// - Channel 2 resets into watchdog duty, which blocks some writes.
// - Frequency mode toggles on low byte match and adds high byte to low.
// - 8-bit PWM sets on low match, clears and reloads on low byte overflow.
// - 16-bit PWM sets on full match and clears on counter overflow.
`timescale 1ns/100ps
`default_nettype none
`include "cca_defs.svh"
module counter_array
   import cca_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // Array control
   input wire logic RUN_I,
   input wire logic IDLE_I,
   input wire logic MODE_WR_I,
   input wire logic [2:0] TIMEBASE_I,
   input wire logic IDLE_SUSPEND_I,
   input wire logic OVF_IRQ_EN_I,
   input wire logic WDOG_EN_I,
   // Count sources
   input wire logic T0_OVF_I,
   input wire logic EXT_COUNT_PIN_I,
   input wire logic EXT_OSC_I,
   // Counter read
   input wire logic COUNT_LOW_RD_I,
   output logic [7:0] COUNT_LOW_O,
   output logic [7:0] COUNT_HIGH_O,
   // Flags
   input wire logic OVF_CLR_I,
   input wire logic [2:0] CH_FLAG_CLR_I,
   output logic OVF_FLAG_O,
   output logic [2:0] CH_FLAG_O,
   output logic IRQ_O,
   // Channel registers
   input wire logic [1:0] CH_SEL_I,
   input wire logic CH_MODE_WR_I,
   input wire logic CH_LOW_WR_I,
   input wire logic CH_HIGH_WR_I,
   input wire logic [7:0] CH_WDATA_I,
   output logic [47:0] CH_VALUE_O,
   // Channel pins
   input wire logic [2:0] CH_PIN_I,
   output logic [2:0] CH_PIN_O,
   output logic [2:0] CH_PIN_OE_O,
   // Watchdog
   output logic WDOG_EN_O,
   output logic WDOG_RESET_O
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [15:0] count;
   logic [15:0] next_count;
   logic [7:0] snap_high;
   logic [2:0] timebase;
   logic idle_suspend;
   logic ovf_irq_en;
   logic wdog;
   logic [3:0] div12;
   logic [1:0] div4;
   logic [2:0] osc_div;
   logic eci_s1, eci_s2, eci_s3;
   logic osc_s1, osc_s2, osc_s3;
   logic [2:0] pin_s1, pin_s2, pin_s3, pin_filt, pin_prev;
   logic src_tick, run, tick, ovf16, ovf8;
   logic [15:0] value [3];
   logic [7:0] mode [3];
   chan_mode_e cmode [3];
   logic [2:0] prev_tog, match16, match8, cap_evt, flag_set, channel_flag_irq_enable;

   assign next_count = count + 16'h1;
   assign COUNT_LOW_O = count[7:0];
   assign COUNT_HIGH_O = snap_high;
   assign WDOG_EN_O = wdog;
   assign CH_VALUE_O = {value[2], value[1], value[0]};

   // ----------------------------------------
   // Array mode register
   // ----------------------------------------
   // Watchdog comes up armed so a runaway program is caught from the first cycle
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         timebase <= TB_DIV12;
         idle_suspend <= 1'b0;
         ovf_irq_en <= 1'b0;
         wdog <= 1'b1;
      end
      else if (MODE_WR_I)
      begin
         ovf_irq_en <= OVF_IRQ_EN_I;
         wdog <= WDOG_EN_I;
         if (!wdog)
         begin
            timebase <= TIMEBASE_I;
            idle_suspend <= IDLE_SUSPEND_I;
         end
      end
   end

   // ----------------------------------------
   // Synchronisers and prescalers
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         {eci_s1, eci_s2, eci_s3} <= 3'h7;
         {osc_s1, osc_s2, osc_s3} <= 3'h0;
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
         pin_s3 <= 3'h0;
         pin_filt <= 3'h0;
         pin_prev <= 3'h0;
      end
      else
      begin
         {eci_s1, eci_s2, eci_s3} <= {EXT_COUNT_PIN_I, eci_s1, eci_s2};
         {osc_s1, osc_s2, osc_s3} <= {EXT_OSC_I, osc_s1, osc_s2};
         pin_s1 <= CH_PIN_I;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         // A level must be seen on two successive cycles before it counts
         for (int i = 0; i < 3; i++)
            if (pin_s2[i] == pin_s3[i])
               pin_filt[i] <= pin_s2[i];
         pin_prev <= pin_filt;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         div12 <= 4'h0;
         div4 <= 2'h0;
         osc_div <= 3'h0;
      end
      else
      begin
         div12 <= (div12 == `DIV12_LAST) ? 4'h0 : div12 + 4'h1;
         div4 <= div4 + 2'h1;
         if (osc_s2 && !osc_s3)
            osc_div <= osc_div + 3'h1;
      end
   end

   // ----------------------------------------
   // Timebase
   // ----------------------------------------
   always_comb
   begin
      case (timebase)
         TB_DIV12: src_tick = (div12 == `DIV12_LAST);
         TB_DIV4: src_tick = (div4 == `DIV4_LAST);
         TB_T0OVF: src_tick = T0_OVF_I;
         TB_ECI: src_tick = eci_s3 && !eci_s2;
         TB_SYS: src_tick = 1'b1;
         TB_OSC8: src_tick = osc_s2 && !osc_s3 && (osc_div == `OSC_DIV_LAST);
         default: src_tick = 1'b0;
      endcase
   end

   // Watchdog forces the counter on; idle suspend stops it only when set
   assign run = (RUN_I || wdog) && !(IDLE_I && idle_suspend);
   assign tick = run && src_tick;
   assign ovf16 = tick && (count == `CNT_MAX);
   assign ovf8 = tick && (count[7:0] == `BYTE_MAX);

   // ----------------------------------------
   // Counter and snapshot
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         count <= `CNT_RST;
      else if (tick)
         count <= next_count;
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         snap_high <= 8'h00;
      else if (COUNT_LOW_RD_I)
         snap_high <= count[15:8];
   end

   // ----------------------------------------
   // Channel decode and events
   // ----------------------------------------
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         cmode[i] = (wdog && i == `WD_CH) ? CM_TIMER : decode_mode(mode[i]);
         channel_flag_irq_enable[i] = mode[i][`MB_CHANNEL_FLAG_IRQ_ENABLE];
         match16[i] = tick && (next_count == value[i]);
         match8[i] = tick && (next_count[7:0] == value[i][7:0]);
         cap_evt[i] = (cmode[i] == CM_CAPTURE) &&
            ((mode[i][`MB_RISING_CAPTURE_ENABLE] && pin_filt[i] && !pin_prev[i]) ||
             (mode[i][`MB_FALLING_CAPTURE_ENABLE] && !pin_filt[i] && pin_prev[i]));
         flag_set[i] = cap_evt[i] || (mode[i][`MB_MAT] && (
            (match16[i] && (cmode[i] == CM_TIMER || cmode[i] == CM_TOGGLE || cmode[i] == CM_WIDE_PWM_SELECT)) ||
            (match8[i] && (cmode[i] == CM_FREQ || cmode[i] == CM_PWM8))));
      end
   end

   // ----------------------------------------
   // Channel registers
   // ----------------------------------------
   // Software writes come after hardware updates so they win in a clash
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (int i = 0; i < 3; i++)
         begin
            value[i] <= 16'h0000;
            mode[i] <= `MODE_RST;
         end
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (cap_evt[i])
               value[i] <= count;
            else if (cmode[i] == CM_FREQ && match8[i])
               value[i][7:0] <= value[i][7:0] + value[i][15:8];
            else if (cmode[i] == CM_PWM8 && ovf8)
               value[i][7:0] <= value[i][15:8];
            if (CH_SEL_I == 2'(i))
            begin
               if (CH_MODE_WR_I && !(wdog && i == `WD_CH))
                  mode[i] <= CH_WDATA_I;
               if (CH_LOW_WR_I)
               begin
                  value[i][7:0] <= CH_WDATA_I;
                  mode[i][`MB_COMPARE_ENABLE] <= 1'b0;
               end
               if (CH_HIGH_WR_I)
               begin
                  // Watchdog refresh reloads the deadline instead of storing the byte
                  value[i][15:8] <= (wdog && i == `WD_CH) ? count[15:8] + value[i][7:0] : CH_WDATA_I;
                  mode[i][`MB_COMPARE_ENABLE] <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Flags and interrupt
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         OVF_FLAG_O <= 1'b0;
         CH_FLAG_O <= 3'h0;
      end
      else
      begin
         // Set beats clear so no event is dropped
         OVF_FLAG_O <= ovf16 || (OVF_FLAG_O && !OVF_CLR_I);
         CH_FLAG_O <= flag_set | (CH_FLAG_O & ~CH_FLAG_CLR_I);
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         IRQ_O <= 1'b0;
      else
         IRQ_O <= (OVF_FLAG_O && ovf_irq_en) || |(CH_FLAG_O & channel_flag_irq_enable);
   end

   // ----------------------------------------
   // Pin outputs
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         CH_PIN_O <= 3'h7;
         CH_PIN_OE_O <= 3'h0;
         prev_tog <= 3'h0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            prev_tog[i] <= (cmode[i] == CM_TOGGLE);
            CH_PIN_OE_O[i] <= (cmode[i] != CM_CAPTURE) && (mode[i][`MB_TOG] || mode[i][`MB_PWM]);
            case (cmode[i])
               CM_TOGGLE:
                  if (!prev_tog[i])
                     CH_PIN_O[i] <= 1'b1;
                  else if (match16[i])
                     CH_PIN_O[i] <= !CH_PIN_O[i];
               CM_FREQ:
                  if (match8[i])
                     CH_PIN_O[i] <= !CH_PIN_O[i];
               CM_PWM8:
                  // A match on the wrap cycle keeps the pin high for full duty
                  if (match8[i])
                     CH_PIN_O[i] <= 1'b1;
                  else if (ovf8)
                     CH_PIN_O[i] <= 1'b0;
               CM_WIDE_PWM_SELECT:
                  if (match16[i])
                     CH_PIN_O[i] <= 1'b1;
                  else if (ovf16)
                     CH_PIN_O[i] <= 1'b0;
               default:
                  if (mode[i][`MB_PWM])
                     CH_PIN_O[i] <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Watchdog expiry
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         WDOG_RESET_O <= 1'b0;
      else
         WDOG_RESET_O <= wdog && ovf8 && (value[`WD_CH][15:8] == count[15:8]);
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   chk_snap_high: assert property (
      COUNT_LOW_RD_I ##1 !COUNT_LOW_RD_I |=> COUNT_HIGH_O == $past(count[15:8], 2))
      else $error("high byte snapshot wrong");
   chk_read_free: assert property (
      tick && COUNT_LOW_RD_I |=> count == $past(next_count))
      else $error("counter disturbed by read");
   chk_ovf_set: assert property (
      ovf16 |=> OVF_FLAG_O && count == `CNT_RST)
      else $error("overflow flag not set");
   chk_ovf_hold: assert property (
      OVF_FLAG_O && !OVF_CLR_I |=> OVF_FLAG_O)
      else $error("overflow flag lost");
   chk_idle_hold: assert property (
      IDLE_I && idle_suspend |=> $stable(count))
      else $error("counter moved in idle");
   chk_idle_run: assert property (
      timebase == TB_SYS && RUN_I && IDLE_I && !idle_suspend |=> count == $past(next_count))
      else $error("counter stopped in idle");
   chk_cap_load: assert property (
      cap_evt[0] |=> value[0] == $past(count) && CH_FLAG_O[0])
      else $error("capture not loaded");
   chk_pin_filter: assert property (
      pin_filt[0] != $past(pin_filt[0]) |-> $past(pin_s2[0]) == $past(pin_s3[0]))
      else $error("unfiltered pin edge");
   chk_low_clear: assert property (
      CH_LOW_WR_I && CH_SEL_I == 2'h0 |=> !mode[0][`MB_COMPARE_ENABLE])
      else $error("compare enable not cleared");
   chk_tog_flip: assert property (
      cmode[1] == CM_TOGGLE && prev_tog[1] && match16[1] |=> CH_PIN_O[1] != $past(CH_PIN_O[1]))
      else $error("toggle missed");
   chk_tog_init: assert property (
      cmode[1] == CM_TOGGLE && !prev_tog[1] |=> CH_PIN_O[1])
      else $error("toggle not initialised");
   chk_wd_lock: assert property (
      wdog && CH_MODE_WR_I && CH_SEL_I == `WD_SEL |=> $stable(mode[`WD_CH]))
      else $error("watchdog channel mode written");

   cov_capture: cover property (cap_evt[0] ##1 CH_FLAG_O[0]);
   cov_overflow: cover property (ovf16 ##1 OVF_FLAG_O);
   cov_toggle: cover property (cmode[1] == CM_TOGGLE && prev_tog[1] && match16[1]);
   cov_wd_reset: cover property (WDOG_RESET_O);
endmodule // counter_array
`default_nettype wire

// File: src/cca_defs.svh
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH
// ----------------------------------------
// Counter and prescaler limits
// ----------------------------------------
`define CNT_MAX 16'hffff
`define CNT_RST 16'h0000
`define BYTE_MAX 8'hff
`define DIV12_LAST 4'hb
`define DIV4_LAST 2'h3
`define OSC_DIV_LAST 3'h7
// ----------------------------------------
// Channel mode byte layout
// ----------------------------------------
`define MB_WIDE_PWM_SELECT 7
`define MB_COMPARE_ENABLE 6
`define MB_RISING_CAPTURE_ENABLE 5
`define MB_FALLING_CAPTURE_ENABLE 4
`define MB_MAT 3
`define MB_TOG 2
`define MB_PWM 1
`define MB_CHANNEL_FLAG_IRQ_ENABLE 0
`define MODE_RST 8'h00
// ----------------------------------------
// Watchdog
// ----------------------------------------
`define WD_CH 2
`define WD_SEL 2'h2
`endif

// File: src/cca_pkg.sv
`include "cca_defs.svh"
package cca_pkg;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      TB_DIV12 = 3'b000,
      TB_DIV4  = 3'b001,
      TB_T0OVF = 3'b010,
      TB_ECI   = 3'b011,
      TB_SYS   = 3'b100,
      TB_OSC8  = 3'b101
   } timebase_e;

   typedef enum logic [2:0] {
      CM_OFF     = 3'b000,
      CM_CAPTURE = 3'b001,
      CM_TIMER   = 3'b010,
      CM_TOGGLE  = 3'b011,
      CM_FREQ    = 3'b100,
      CM_PWM8    = 3'b101,
      CM_WIDE_PWM_SELECT   = 3'b110
   } chan_mode_e;

   // Mode byte to operating mode
   function automatic chan_mode_e decode_mode(input logic [7:0] m);
      logic cap;
      cap = m[`MB_RISING_CAPTURE_ENABLE] | m[`MB_FALLING_CAPTURE_ENABLE];
      if (cap && !m[`MB_MAT] && !m[`MB_TOG] && !m[`MB_PWM])
         return CM_CAPTURE;
      else if (cap || !m[`MB_COMPARE_ENABLE])
         return CM_OFF;
      else if (m[`MB_TOG] && m[`MB_PWM])
         return CM_FREQ;
      else if (m[`MB_PWM])
         return m[`MB_WIDE_PWM_SELECT] ? CM_WIDE_PWM_SELECT : CM_PWM8;
      else if (m[`MB_MAT] && m[`MB_TOG])
         return CM_TOGGLE;
      else if (m[`MB_MAT])
         return CM_TIMER;
      return CM_OFF;
   endfunction
endpackage

// File: testbench/pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module pin_model
(
   // Clock
   input wire logic clk,
   // Pins towards the array
   output logic [2:0] ch_pin,
   output logic count_pin
);
   initial
   begin
      ch_pin = 3'h0;
      count_pin = 1'h1;
   end
   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Callers hold a level two cycles or more; hold 0 is a deliberate glitch
   task automatic drive(input int ch, input logic lvl, input int hold);
      @(posedge clk) #1 ch_pin[ch] = lvl;
      repeat (hold) @(posedge clk);
   endtask
   // Falling edges no faster than a quarter of the clock rate
   task automatic falls(input int n);
      repeat (n)
      begin
         @(posedge clk) #1 count_pin = 1'h0;
         repeat (2) @(posedge clk);
         #1 count_pin = 1'h1;
         @(posedge clk);
      end
   endtask
endmodule // pin_model
`default_nettype wire

// File: testbench/counter_array_tb.sv
`timescale 1ns/100ps
`default_nettype none
module counter_array_tb
   import cca_pkg::*;
;
   localparam int LIMIT = 90000;
   logic ref_clk = 1'h0, rst_n, run, idle, mode_wr, idle_susp, ovf_en, wdog_en, t0_ovf, ext_osc, cnt_rd, ovf_clr;
   logic [2:0] timebase, ch_clr, ch_flag, pin_out, pin_oe, ch_pin;
   logic [1:0] ch_sel;
   logic ch_mode_wr, ch_low_wr, ch_high_wr, ovf_flag, irq, wdog_on, wdog_rst, count_pin;
   logic [7:0] ch_wdata, cnt_lo, cnt_hi;
   logic [47:0] ch_value;
   logic [15:0] a, b, c;
   int miscompares = 0, check_count = 0, cycles = 0, n;
   always #20 ref_clk = ~ref_clk;
   counter_array u_dut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .RUN_I(run), .IDLE_I(idle), .MODE_WR_I(mode_wr),
      .TIMEBASE_I(timebase), .IDLE_SUSPEND_I(idle_susp), .OVF_IRQ_EN_I(ovf_en), .WDOG_EN_I(wdog_en),
      .T0_OVF_I(t0_ovf), .EXT_COUNT_PIN_I(count_pin), .EXT_OSC_I(ext_osc), .COUNT_LOW_RD_I(cnt_rd),
      .COUNT_LOW_O(cnt_lo), .COUNT_HIGH_O(cnt_hi), .OVF_CLR_I(ovf_clr), .CH_FLAG_CLR_I(ch_clr),
      .OVF_FLAG_O(ovf_flag), .CH_FLAG_O(ch_flag), .IRQ_O(irq), .CH_SEL_I(ch_sel), .CH_MODE_WR_I(ch_mode_wr),
      .CH_LOW_WR_I(ch_low_wr), .CH_HIGH_WR_I(ch_high_wr), .CH_WDATA_I(ch_wdata), .CH_VALUE_O(ch_value),
      .CH_PIN_I(ch_pin), .CH_PIN_O(pin_out), .CH_PIN_OE_O(pin_oe), .WDOG_EN_O(wdog_on), .WDOG_RESET_O(wdog_rst));
   pin_model u_far (.clk(ref_clk), .ch_pin(ch_pin), .count_pin(count_pin));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic set_mode(input logic [2:0] tb, input logic susp, input logic wd);
      timebase = tb;
      idle_susp = susp;
      wdog_en = wd;
      mode_wr = 1'h1;
      tick(1);
      mode_wr = 1'h0;
   endtask
   // Kind 0 writes the mode byte, 1 the low byte, 2 the high byte
   task automatic wr_ch(input logic [1:0] ch, input int kind, input logic [7:0] d);
      ch_sel = ch;
      ch_wdata = d;
      ch_mode_wr = (kind == 0);
      ch_low_wr = (kind == 1);
      ch_high_wr = (kind == 2);
      tick(1);
      {ch_mode_wr, ch_low_wr, ch_high_wr} = 3'h0;
   endtask
   task automatic wr16(input logic [1:0] ch, input logic [15:0] v);
      wr_ch(ch, 1, v[7:0]);
      wr_ch(ch, 2, v[15:8]);
   endtask
   // Low byte is taken in the read cycle, the high byte from the snapshot after it
   task automatic rd(output logic [15:0] v);
      cnt_rd = 1'h1;
      v[7:0] = cnt_lo;
      tick(1);
      cnt_rd = 1'h0;
      v[15:8] = cnt_hi;
   endtask
   task automatic t0(input int k);
      repeat (k)
      begin
         t0_ovf = 1'h1;
         tick(1);
         t0_ovf = 1'h0;
         tick(1);
      end
   endtask
   task automatic clr(input int ch);
      ch_clr[ch] = 1'h1;
      tick(1);
      ch_clr = 3'h0;
      tick(1);
   endtask
   // Counts advanced over k cycles, with reads at both ends
   task automatic span(input int k, input logic [7:0] exp, input string what);
      rd(a);
      tick(k - 1);
      rd(b);
      chk(what, exp, b[7:0] - a[7:0]);
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         miscompares++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {rst_n, idle, mode_wr, idle_susp, wdog_en, t0_ovf, ext_osc, cnt_rd, ovf_clr} = 9'h000;
      {ch_mode_wr, ch_low_wr, ch_high_wr, ch_clr, ch_sel, ch_wdata, timebase} = 19'h00000;
      run = 1'h1;
      ovf_en = 1'h1;
      repeat (5) @(posedge ref_clk);
      #1 rst_n = 1'h1;
      chk("reset_outs", 48'h0e01, {pin_out, pin_oe, ch_flag, ovf_flag, irq, wdog_on});
      n = 0;
      while (wdog_rst !== 1'h1 && n < 3300)
      begin
         tick(1);
         n++;
      end
      chk("wdog_expiry", 48'h1, (n >= 3060 && n <= 3090));
      set_mode(TB_SYS, 1'h0, 1'h0);
      chk("wdog_off", 48'h0, wdog_on);
      $display("test reset and watchdog done");
      set_mode(TB_DIV12, 1'h0, 1'h0);
      span(120, 8'h0a, "div12");
      set_mode(TB_DIV4, 1'h0, 1'h0);
      span(40, 8'h0a, "div4");
      set_mode(TB_SYS, 1'h0, 1'h0);
      span(10, 8'h0a, "sysclk");
      set_mode(TB_T0OVF, 1'h0, 1'h0);
      rd(a);
      t0(7);
      rd(b);
      chk("t0_count", 8'h07, b[7:0] - a[7:0]);
      set_mode(TB_ECI, 1'h0, 1'h0);
      rd(a);
      u_far.falls(5);
      tick(5);
      rd(b);
      chk("pin_count", 8'h05, b[7:0] - a[7:0]);
      set_mode(TB_OSC8, 1'h0, 1'h0);
      rd(a);
      repeat (16)
      begin
         ext_osc = 1'h1;
         tick(2);
         ext_osc = 1'h0;
         tick(2);
      end
      tick(4);
      rd(b);
      chk("osc8_count", 8'h02, b[7:0] - a[7:0]);
      idle = 1'h1;
      set_mode(TB_SYS, 1'h1, 1'h0);
      span(10, 8'h00, "idle_hold");
      set_mode(TB_SYS, 1'h0, 1'h0);
      span(10, 8'h0a, "idle_run");
      idle = 1'h0;
      $display("test timebase done");
      set_mode(TB_T0OVF, 1'h0, 1'h0);
      rd(a);
      t0(256);
      chk("snapshot", a[15:8], cnt_hi);
      rd(b);
      chk("count16", a + 16'h0100, b);
      c = b;
      wr_ch(2'h0, 0, 8'h49);
      wr16(2'h0, c + 16'h0005);
      chk("ch0_value", c + 16'h0005, ch_value[15:0]);
      t0(4);
      tick(2);
      chk("early_flag", 48'h0, ch_flag[0]);
      t0(1);
      tick(2);
      chk("match_flag", 48'h1, ch_flag[0]);
      chk("ch_irq", 48'h1, irq);
      tick(4);
      chk("flag_stays", 48'h1, ch_flag[0]);
      clr(0);
      chk("flag_clear", 48'h0, ch_flag[0]);
      wr16(2'h0, c + 16'h0007);
      wr_ch(2'h0, 1, c[7:0] + 8'h07);
      t0(2);
      tick(2);
      chk("low_wr_disarm", 48'h0, ch_flag[0]);
      $display("test compare done");
      wr_ch(2'h1, 0, 8'h4c);
      tick(1);
      chk("tog_start", 48'h3, {pin_out[1], pin_oe[1]});
      rd(c);
      wr16(2'h1, c + 16'h0003);
      t0(2);
      tick(2);
      chk("tog_before", 48'h1, pin_out[1]);
      t0(1);
      tick(2);
      chk("tog_match", 48'h0, pin_out[1]);
      wr_ch(2'h1, 0, 8'h00);
      wr_ch(2'h1, 0, 8'h4c);
      tick(1);
      chk("tog_reinit", 48'h1, pin_out[1]);
      $display("test toggle done");
      rd(c);
      wr_ch(2'h0, 0, 8'h21);
      u_far.drive(0, 1'h1, 8);
      chk("cap_rise", {c, 16'h1, 16'h0}, {ch_value[15:0], 15'h0, ch_flag[0], 15'h0, pin_oe[0]});
      clr(0);
      t0(3);
      u_far.drive(0, 1'h0, 8);
      chk("rise_only", 48'h0, ch_flag[0]);
      wr_ch(2'h0, 0, 8'h11);
      u_far.drive(0, 1'h1, 8);
      chk("fall_only", 48'h0, ch_flag[0]);
      u_far.drive(0, 1'h0, 8);
      chk("cap_fall", {c + 16'h0003, 16'h1}, {ch_value[15:0], 15'h0, ch_flag[0]});
      clr(0);
      wr_ch(2'h0, 0, 8'h31);
      t0(2);
      u_far.drive(0, 1'h1, 8);
      chk("cap_both", {c + 16'h0005, 16'h1}, {ch_value[15:0], 15'h0, ch_flag[0]});
      clr(0);
      u_far.drive(0, 1'h0, 0);
      u_far.drive(0, 1'h1, 8);
      chk("glitch", 48'h0, ch_flag[0]);
      $display("test capture done");
      rd(c);
      wr_ch(2'h2, 0, 8'h82);
      wr16(2'h2, c + 16'h0003);
      t0(2);
      tick(2);
      chk("wide_pwm_select_low", 48'h1, {pin_out[2], pin_oe[2]});
      t0(1);
      tick(2);
      chk("wide_pwm_select_high", 48'h3, {pin_out[2], pin_oe[2]});
      $display("test pwm done");
      set_mode(TB_SYS, 1'h0, 1'h0);
      n = 0;
      while (ovf_flag !== 1'h1 && n < 70000)
      begin
         tick(1);
         n++;
      end
      chk("ovf_flag", 48'h1, ovf_flag);
      tick(2);
      chk("ovf_irq", 48'h1, irq);
      tick(4);
      chk("ovf_stays", 48'h1, ovf_flag);
      ovf_clr = 1'h1;
      tick(1);
      ovf_clr = 1'h0;
      tick(1);
      chk("ovf_clear", 48'h0, ovf_flag);
      $display("test overflow done");
      give_verdict();
   end
endmodule // counter_array_tb
`default_nettype wire
